// [rtcz_params.svh]
// Register indices, field positions, reset values and timing counts of the RTC control block
`ifndef RTCZ_PARAMS_SVH
`define RTCZ_PARAMS_SVH
// ==========================================
// Register indices (byte address is four times the index)
`define RTCZ_CTL0_IDX 20'hFFF9D
`define RTCZ_CTL1_IDX 20'hFFF9E
`define RTCZ_STAT_IDX 20'hFFF9F
`define RTCZ_MASK_IDX 20'hFFFA0
`define RTCZ_TIME_IDX 20'hFFFA1
`define RTCZ_DATE_IDX 20'hFFFA2
// ==========================================
// Field positions
`define RTCZ_HOLD_BIT 0
`define RTCZ_ALT_BIT 1
`define RTCZ_EVT_BIT 0
`define RTCZ_REQ_BIT 1
`define RTCZ_SEC_LSB 0
`define RTCZ_MIN_LSB 8
`define RTCZ_HOUR_LSB 16
`define RTCZ_DAY_LSB 0
`define RTCZ_MON_LSB 8
// ==========================================
// Reset values
`define RTCZ_CTL0_RST 8'h00
`define RTCZ_CTL1_RST 2'h0
`define RTCZ_MASK_RST 2'h0
`define RTCZ_DAY_RST 5'h01
`define RTCZ_MON_RST 4'h1
// ==========================================
// Periodic selector codes
`define RTCZ_SEL_OFF 3'h0
`define RTCZ_SEL_HALF 3'h1
`define RTCZ_SEL_SEC 3'h2
`define RTCZ_SEL_MIN 3'h3
`define RTCZ_SEL_HOUR 3'h4
`define RTCZ_SEL_DAY 3'h5
// ==========================================
// Timing
`define RTCZ_CLK_HZ 40000000
`define RTCZ_FINE_HZ 32768
`define RTCZ_HALF_SEC_MS 500
`define RTCZ_HALF_CNT (`RTCZ_FINE_HZ * `RTCZ_HALF_SEC_MS / 1000)
`endif

// [rtcz_pkg.sv]
// Types and hour conversion helpers of the RTC control block
package rtcz_pkg;
   // ==========================================
   // Control register 0 layout
   typedef struct packed {
      logic run;
      logic unused;
      logic one_hz_en;
      logic fine_en;
      logic fmt24;
      logic [2:0] sel;
   } rtcz_ctl0_t;

   // Time of day, hour always kept in 24-hour form
   typedef struct packed {
      logic [5:0] sec;
      logic [5:0] min;
      logic [4:0] hour;
      logic [4:0] day;
      logic [3:0] month;
   } rtcz_time_t;

   typedef enum logic {APB_IDLE, APB_ANSWER} rtcz_apb_state_t;

   // Hour as software sees it: 24-hour plain, or pm flag in bit 5 with 1..12
   function automatic logic [5:0] rtcz_hour_show(input logic [4:0] h, input logic fmt24);
      logic [4:0] h12;
      h12 = (h >= 5'h0C) ? h - 5'h0C : h;
      if (fmt24) begin
         rtcz_hour_show = {1'b0, h};
      end else begin
         rtcz_hour_show = {(h >= 5'h0C), (h12 == 5'h00) ? 5'h0C : h12};
      end
   endfunction : rtcz_hour_show

   // Inverse of the above, for software writes of the hour
   function automatic logic [4:0] rtcz_hour_load(input logic [5:0] v, input logic fmt24);
      logic [4:0] base;
      base = (v[4:0] == 5'h0C) ? 5'h00 : v[4:0];
      if (fmt24) begin
         rtcz_hour_load = v[4:0];
      end else begin
         rtcz_hour_load = v[5] ? base + 5'h0C : base;
      end
   endfunction : rtcz_hour_load
endpackage : rtcz_pkg

// [rtcz_tick.sv]
// Fine clock and half-second tick generator
`timescale 1ns/1ps
`include "rtcz_params.svh"
module rtcz_tick #(
   parameter int CLK_HZ = `RTCZ_CLK_HZ,
   parameter int FINE_HZ = `RTCZ_FINE_HZ,
   parameter int HALF_CNT = `RTCZ_HALF_CNT
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic run,
   output logic fine_lvl,
   output logic one_hz_lvl,
   output logic half_tick,
   output logic sec_tick
);
   localparam logic [26:0] STEP = 27'(2 * FINE_HZ);
   localparam logic [26:0] WRAP = 27'(CLK_HZ);
   localparam logic [13:0] LAST = 14'(HALF_CNT - 1);
   logic [26:0] acc_reg, acc_next, acc_sum;
   logic [13:0] cnt_reg, cnt_next;
   logic fine_next, hz_next, half_next, sec_next, fine_rise;

   // Phase accumulator: two toggles per fine period, jitter of one core cycle
   always_comb begin
      acc_sum = acc_reg + STEP;
      acc_next = acc_sum;
      fine_next = fine_lvl;
      fine_rise = 1'b0;
      if (acc_sum >= WRAP) begin
         acc_next = acc_sum - WRAP;
         fine_next = ~fine_lvl;
         fine_rise = ~fine_lvl;
      end
      cnt_next = cnt_reg;
      hz_next = one_hz_lvl;
      half_next = 1'b0;
      sec_next = 1'b0;
      // Stopped counter holds its prescaler at zero so a restart begins a full second
      if (!run) begin
         cnt_next = 14'h0000;
         hz_next = 1'b0;
      end else if (fine_rise) begin
         cnt_next = (cnt_reg == LAST) ? 14'h0000 : cnt_reg + 14'h0001;
         if (cnt_reg == LAST) begin
            half_next = 1'b1;
            hz_next = ~one_hz_lvl;
            sec_next = one_hz_lvl;
         end
      end
   end

   // State registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         acc_reg <= 27'h0000000;
         cnt_reg <= 14'h0000;
         fine_lvl <= 1'b0;
         one_hz_lvl <= 1'b0;
         half_tick <= 1'b0;
         sec_tick <= 1'b0;
      end else begin
         acc_reg <= acc_next;
         cnt_reg <= cnt_next;
         fine_lvl <= fine_next;
         one_hz_lvl <= hz_next;
         half_tick <= half_next;
         sec_tick <= sec_next;
      end
   end
endmodule : rtcz_tick

// [rtcz_timecount.sv]
// Time-of-day and calendar counter with rollover events
`timescale 1ns/1ps
`include "rtcz_params.svh"
module rtcz_timecount
   import rtcz_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic adv,
   input wire logic load,
   input rtcz_time_t load_val,
   output rtcz_time_t now,
   output logic min_ev,
   output logic hour_ev,
   output logic day_ev,
   output logic month_ev
);
   rtcz_time_t now_next;
   logic min_n, hour_n, day_n, mon_n;

   // Month lengths, no leap year
   function automatic logic [4:0] days_in(input logic [3:0] m);
      case (m)
         4'h2: days_in = 5'h1C;
         4'h4, 4'h6, 4'h9, 4'hB: days_in = 5'h1E;
         default: days_in = 5'h1F;
      endcase
   endfunction : days_in

   // Carry chain; a load wins over an advance in the same cycle
   always_comb begin
      now_next = now;
      min_n = 1'b0;
      hour_n = 1'b0;
      day_n = 1'b0;
      mon_n = 1'b0;
      if (load) begin
         now_next = load_val;
      end else if (adv) begin
         now_next.sec = now.sec + 6'h01;
         if (now.sec >= 6'h3B) begin
            now_next.sec = 6'h00;
            min_n = 1'b1;
            now_next.min = now.min + 6'h01;
            if (now.min >= 6'h3B) begin
               now_next.min = 6'h00;
               hour_n = 1'b1;
               now_next.hour = now.hour + 5'h01;
               if (now.hour >= 5'h17) begin
                  now_next.hour = 5'h00;
                  day_n = 1'b1;
                  now_next.day = now.day + 5'h01;
                  if (now.day >= days_in(now.month)) begin
                     now_next.day = 5'h01;
                     mon_n = 1'b1;
                     now_next.month = (now.month >= 4'hC) ? 4'h1 : now.month + 4'h1;
                  end
               end
            end
         end
      end
   end

   // Registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         now <= '{sec: 6'h00, min: 6'h00, hour: 5'h00, day: `RTCZ_DAY_RST,
                  month: `RTCZ_MON_RST};
         min_ev <= 1'b0;
         hour_ev <= 1'b0;
         day_ev <= 1'b0;
         month_ev <= 1'b0;
      end else begin
         now <= now_next;
         min_ev <= min_n;
         hour_ev <= hour_n;
         day_ev <= day_n;
         month_ev <= mon_n;
      end
   end
endmodule : rtcz_timecount

// [rtcz_top.sv]
// RTC control block: APB registers, output pins and periodic interrupt
`timescale 1ns/1ps
`include "rtcz_params.svh"

// ==========================================
// Top level
module rtcz_top
   import rtcz_pkg::*;
#(
   parameter int CLK_HZ = `RTCZ_CLK_HZ,
   parameter int HALF_CNT = `RTCZ_HALF_CNT
) (
   // Clock and reset
   input wire logic CORE_CLK,
   input wire logic RESETN,
   // APB slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [21:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [3:0] PSTRB,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // Interrupt
   output logic PERIODIC_TICK_IRQ,
   // Clock output pins
   output logic ONE_HZ_PIN,
   output logic ONE_HZ_PIN_OE,
   output logic FINE_CLOCK_PIN,
   output logic FINE_CLOCK_PIN_OE,
   output logic ALT_CLOCK_OUT_EN
);

   // ==========================================
   // Address decode
   typedef enum logic [2:0] {
      SEL_NONE, SEL_CTL0, SEL_CTL1, SEL_STAT, SEL_MASK, SEL_TIME, SEL_DATE
   } rtcz_rsel_t;

   // Byte address of a register index
   function automatic logic [21:0] addr_of(input logic [19:0] idx);
      addr_of = {idx, 2'b00};
   endfunction : addr_of

   // Misaligned or unknown addresses fall to SEL_NONE and get an error
   function automatic rtcz_rsel_t decode(input logic [21:0] a);
      if (a == addr_of(`RTCZ_CTL0_IDX)) begin
         decode = SEL_CTL0;
      end else if (a == addr_of(`RTCZ_CTL1_IDX)) begin
         decode = SEL_CTL1;
      end else if (a == addr_of(`RTCZ_STAT_IDX)) begin
         decode = SEL_STAT;
      end else if (a == addr_of(`RTCZ_MASK_IDX)) begin
         decode = SEL_MASK;
      end else if (a == addr_of(`RTCZ_TIME_IDX)) begin
         decode = SEL_TIME;
      end else if (a == addr_of(`RTCZ_DATE_IDX)) begin
         decode = SEL_DATE;
      end else begin
         decode = SEL_NONE;
      end
   endfunction : decode

   // Byte lanes of a write merged into the old word
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] strb);
      logic [31:0] m;
      m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
      merge = (old & ~m) | (wd & m);
   endfunction : merge

   // ==========================================
   // Declarations
   rtcz_ctl0_t ctl0_reg, ctl0_next;
   logic [1:0] ctl1_reg, ctl1_next;
   logic [1:0] stat_reg, stat_next;
   logic [1:0] mask_reg, mask_next;
   logic pend_reg, pend_next;
   rtcz_apb_state_t apb_reg, apb_next;
   logic [31:0] prdata_next, rd_word, wr_word;
   logic pready_next, pslverr_next;
   logic irq_next, hz_pin_next, fine_pin_next;
   rtcz_rsel_t rsel;
   logic wr_fire, hold, adv, event_hit, tc_load;
   rtcz_time_t now, load_val;
   logic fine_lvl, one_hz_lvl, half_tick, sec_tick;
   logic min_ev, hour_ev, day_ev, month_ev;

   assign hold = ctl1_reg[`RTCZ_HOLD_BIT];
   assign rsel = decode(PADDR);
   // Write lands only on the access edge with PREADY high
   assign wr_fire = (apb_reg == APB_ANSWER) && PSEL && PENABLE && PWRITE && PREADY;

   // ==========================================
   // Prescaler and calendar
   rtcz_tick #(
      .CLK_HZ(CLK_HZ),
      .FINE_HZ(`RTCZ_FINE_HZ),
      .HALF_CNT(HALF_CNT)
   ) u_tick (
      .clk(CORE_CLK),
      .rst_n(RESETN),
      .run(ctl0_reg.run),
      .fine_lvl(fine_lvl),
      .one_hz_lvl(one_hz_lvl),
      .half_tick(half_tick),
      .sec_tick(sec_tick)
   );

   rtcz_timecount u_count (
      .clk(CORE_CLK),
      .rst_n(RESETN),
      .adv(adv),
      .load(tc_load),
      .load_val(load_val),
      .now(now),
      .min_ev(min_ev),
      .hour_ev(hour_ev),
      .day_ev(day_ev),
      .month_ev(month_ev)
   );

   // One second arriving during hold is kept and applied at release; further seconds in the same hold are lost
   // Limitation: a tick landing exactly on the release cycle merges with the pending one
   assign adv = ctl0_reg.run && !hold && (sec_tick || pend_reg);

   // ==========================================
   // Read mux
   always_comb begin
      rd_word = 32'h00000000;
      case (rsel)
         // Bit 6 is forced to zero on read
         SEL_CTL0: rd_word[7:0] = {ctl0_reg.run, 1'b0, ctl0_reg[5:0]};
         SEL_CTL1: rd_word[1:0] = ctl1_reg;
         SEL_STAT: rd_word[1:0] = stat_reg;
         SEL_MASK: rd_word[1:0] = mask_reg;
         SEL_TIME: begin
            rd_word[`RTCZ_SEC_LSB +: 6] = now.sec;
            rd_word[`RTCZ_MIN_LSB +: 6] = now.min;
            // Hour shown in the format chosen now, so a format change converts it
            rd_word[`RTCZ_HOUR_LSB +: 6] = rtcz_hour_show(now.hour, ctl0_reg.fmt24);
         end
         SEL_DATE: begin
            rd_word[`RTCZ_DAY_LSB +: 5] = now.day;
            rd_word[`RTCZ_MON_LSB +: 4] = now.month;
         end
         default: rd_word = 32'h00000000;
      endcase
   end

   // ==========================================
   // Periodic event selection
   always_comb begin
      case (ctl0_reg.sel)
         `RTCZ_SEL_OFF: event_hit = 1'b0;
         `RTCZ_SEL_HALF: event_hit = half_tick && ctl0_reg.run;
         `RTCZ_SEL_SEC: event_hit = adv;
         `RTCZ_SEL_MIN: event_hit = min_ev;
         `RTCZ_SEL_HOUR: event_hit = hour_ev;
         `RTCZ_SEL_DAY: event_hit = day_ev;
         default: event_hit = month_ev;
      endcase
   end

   // ==========================================
   // Register writes, W1C status and calendar load
   always_comb begin
      ctl0_next = ctl0_reg;
      ctl1_next = ctl1_reg;
      mask_next = mask_reg;
      stat_next = stat_reg;
      tc_load = 1'b0;
      load_val = now;
      wr_word = merge(rd_word, PWDATA, PSTRB);
      pend_next = pend_reg;
      if (!hold || !ctl0_reg.run) begin
         pend_next = 1'b0;
      end else if (sec_tick) begin
         pend_next = 1'b1;
      end
      if (wr_fire) begin
         case (rsel)
            SEL_CTL0: begin
               ctl0_next = rtcz_ctl0_t'(wr_word[7:0]);
               ctl0_next.unused = 1'b0;
            end
            SEL_CTL1: ctl1_next = wr_word[1:0];
            SEL_MASK: mask_next = wr_word[1:0];
            SEL_STAT: stat_next = stat_reg & ~(PWDATA[1:0] & {2{PSTRB[0]}});
            SEL_TIME: begin
               tc_load = 1'b1;
               load_val.sec = wr_word[`RTCZ_SEC_LSB +: 6];
               load_val.min = wr_word[`RTCZ_MIN_LSB +: 6];
               load_val.hour = rtcz_hour_load(wr_word[`RTCZ_HOUR_LSB +: 6], ctl0_reg.fmt24);
            end
            SEL_DATE: begin
               tc_load = 1'b1;
               load_val.day = wr_word[`RTCZ_DAY_LSB +: 5];
               load_val.month = wr_word[`RTCZ_MON_LSB +: 4];
            end
            default: ;
         endcase
      end
      // A new event wins over a clear in the same cycle
      if (event_hit) begin
         stat_next = stat_next | 2'b11;
      end
   end

   // Register state
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         ctl0_reg <= rtcz_ctl0_t'(`RTCZ_CTL0_RST);
         ctl1_reg <= `RTCZ_CTL1_RST;
         mask_reg <= `RTCZ_MASK_RST;
         stat_reg <= 2'h0;
         pend_reg <= 1'b0;
      end else begin
         ctl0_reg <= ctl0_next;
         ctl1_reg <= ctl1_next;
         mask_reg <= mask_next;
         stat_reg <= stat_next;
         pend_reg <= pend_next;
      end
   end

   // ==========================================
   // APB answer: one fixed cycle of setup, ready on the first access cycle
   always_comb begin
      apb_next = apb_reg;
      prdata_next = PRDATA;
      pready_next = 1'b0;
      pslverr_next = PSLVERR;
      case (apb_reg)
         APB_IDLE: begin
            if (PSEL && !PENABLE) begin
               apb_next = APB_ANSWER;
               pready_next = 1'b1;
               prdata_next = PWRITE ? 32'h00000000 : rd_word;
               pslverr_next = (rsel == SEL_NONE);
            end
         end
         APB_ANSWER: begin
            // Data stays put after the transfer until the next setup
            if (PSEL && PENABLE) begin
               apb_next = APB_IDLE;
            end else begin
               pready_next = 1'b1;
            end
         end
         default: apb_next = APB_IDLE;
      endcase
   end

   // Bus state
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         apb_reg <= APB_IDLE;
         PRDATA <= 32'h00000000;
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
      end else begin
         apb_reg <= apb_next;
         PRDATA <= prdata_next;
         PREADY <= pready_next;
         PSLVERR <= pslverr_next;
      end
   end

   // ==========================================
   // Pins and interrupt, all registered so they never glitch from decode logic
   always_comb begin
      irq_next = |(stat_reg & mask_reg);
      hz_pin_next = ctl0_reg.one_hz_en && one_hz_lvl;
      fine_pin_next = ctl0_reg.fine_en && fine_lvl;
   end

   // Output flops
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         PERIODIC_TICK_IRQ <= 1'b0;
         ONE_HZ_PIN <= 1'b0;
         ONE_HZ_PIN_OE <= 1'b0;
         FINE_CLOCK_PIN <= 1'b0;
         FINE_CLOCK_PIN_OE <= 1'b0;
         ALT_CLOCK_OUT_EN <= 1'b0;
      end else begin
         PERIODIC_TICK_IRQ <= irq_next;
         ONE_HZ_PIN <= hz_pin_next;
         ONE_HZ_PIN_OE <= ctl0_reg.one_hz_en;
         FINE_CLOCK_PIN <= fine_pin_next;
         FINE_CLOCK_PIN_OE <= ctl0_reg.fine_en;
         ALT_CLOCK_OUT_EN <= ctl1_reg[`RTCZ_ALT_BIT];
      end
   end
endmodule : rtcz_top

// [rtcz_top_sva.sv]
// Port-level assertion checker for the RTC control block
`timescale 1ns/1ps
`include "rtcz_params.svh"
module rtcz_top_sva #(
   parameter int CLK_HZ = `RTCZ_CLK_HZ,
   parameter int HALF_CNT = `RTCZ_HALF_CNT
) (
   // Clock and reset
   input wire logic CORE_CLK,
   input wire logic RESETN,
   // APB slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [21:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [3:0] PSTRB,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   // Interrupt and pins
   input wire logic PERIODIC_TICK_IRQ,
   input wire logic ONE_HZ_PIN,
   input wire logic ONE_HZ_PIN_OE,
   input wire logic FINE_CLOCK_PIN,
   input wire logic FINE_CLOCK_PIN_OE,
   input wire logic ALT_CLOCK_OUT_EN
);
   localparam logic [21:0] A_CTL0 = {`RTCZ_CTL0_IDX, 2'b00};
   localparam logic [21:0] A_MASK = {`RTCZ_MASK_IDX, 2'b00};
   logic xfer;
   logic mapped;
   logic wr_ctl0;
   logic wr_mask;
   logic [1:0] oe_reg;
   logic [1:0] oe_next;
   logic run_reg;
   logic run_next;
   logic mz_reg;
   logic mz_next;
   logic [1:0] stop_reg;
   logic [1:0] stop_next;

   // Completed transfers and the register they hit
   assign xfer = PSEL && PENABLE && PREADY;
   assign mapped = (PADDR[1:0] == 2'h0) && (PADDR[21:2] inside {`RTCZ_CTL0_IDX,
      `RTCZ_CTL1_IDX, `RTCZ_STAT_IDX, `RTCZ_MASK_IDX, `RTCZ_TIME_IDX, `RTCZ_DATE_IDX});
   assign wr_ctl0 = xfer && PWRITE && PSTRB[0] && (PADDR == A_CTL0);
   assign wr_mask = xfer && PWRITE && PSTRB[0] && (PADDR == A_MASK);

   // Shadow of software intent; the stop counter saturates so in-flight events drain first
   always_comb begin
      oe_next = oe_reg;
      run_next = run_reg;
      mz_next = mz_reg;
      stop_next = run_reg ? 2'h0 : ((stop_reg == 2'h3) ? 2'h3 : stop_reg + 2'h1);
      if (wr_ctl0) begin
         oe_next = PWDATA[5:4];
         run_next = PWDATA[7];
      end
      if (wr_mask) begin
         mz_next = (PWDATA[1:0] == 2'h0);
      end
   end

   // Shadow registers
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         oe_reg <= 2'h0;
         run_reg <= 1'b0;
         mz_reg <= 1'b1;
         stop_reg <= 2'h3;
      end else begin
         oe_reg <= oe_next;
         run_reg <= run_next;
         mz_reg <= mz_next;
         stop_reg <= stop_next;
      end
   end

   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RESETN);

   // ==========================================
   // Bus and register properties
   sequence s_setup;
      PSEL && !PENABLE;
   endsequence
   sequence s_read_ctl0;
      xfer && !PWRITE && (PADDR == A_CTL0);
   endsequence

   a_ready_zero_wait: assert property (s_setup |=> PREADY)
      else $error("ready missing in first access cycle");
   a_ready_one_cycle: assert property (PREADY |=> !PREADY)
      else $error("ready held longer than one cycle");
   a_err_unmapped: assert property (xfer && !mapped |-> PSLVERR && (PRDATA == 32'h0))
      else $error("unmapped access not refused");
   a_err_mapped: assert property (xfer && mapped |-> !PSLVERR)
      else $error("mapped access refused");
   a_bit6_zero: assert property (s_read_ctl0 |-> (PRDATA[31:8] == 24'h0) && !PRDATA[6])
      else $error("control bit 6 reads nonzero");
   a_oe_follow: assert property ($past(wr_ctl0, 2) |->
      {ONE_HZ_PIN_OE, FINE_CLOCK_PIN_OE} == oe_reg)
      else $error("output enables do not follow control write");
   a_slow_pin_off: assert property (!ONE_HZ_PIN_OE |-> !ONE_HZ_PIN)
      else $error("slow pin active while disabled");
   a_fine_pin_off: assert property (!FINE_CLOCK_PIN_OE |-> !FINE_CLOCK_PIN)
      else $error("fine pin active while disabled");
   a_irq_masked: assert property (mz_reg && $past(mz_reg) |-> !PERIODIC_TICK_IRQ)
      else $error("interrupt raised while fully masked");
   a_stop_quiet: assert property (&stop_reg |-> !ONE_HZ_PIN && !$rose(PERIODIC_TICK_IRQ))
      else $error("activity while counter stopped");
endmodule : rtcz_top_sva

bind rtcz_top rtcz_top_sva #(.CLK_HZ(CLK_HZ), .HALF_CNT(HALF_CNT)) u_sva (.CORE_CLK(CORE_CLK),
   .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
   .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
   .PERIODIC_TICK_IRQ(PERIODIC_TICK_IRQ), .ONE_HZ_PIN(ONE_HZ_PIN),
   .ONE_HZ_PIN_OE(ONE_HZ_PIN_OE), .FINE_CLOCK_PIN(FINE_CLOCK_PIN),
   .FINE_CLOCK_PIN_OE(FINE_CLOCK_PIN_OE), .ALT_CLOCK_OUT_EN(ALT_CLOCK_OUT_EN));

// [rtc_control_zero_bench.sv]
// Self-checking testbench of the RTC control block
`timescale 1ns/1ps
`include "rtcz_params.svh"
module rtc_control_zero_bench;
   localparam logic [21:0] A_CTL0 = {`RTCZ_CTL0_IDX, 2'b00};
   localparam logic [21:0] A_CTL1 = {`RTCZ_CTL1_IDX, 2'b00};
   localparam logic [21:0] A_STAT = {`RTCZ_STAT_IDX, 2'b00};
   localparam logic [21:0] A_MASK = {`RTCZ_MASK_IDX, 2'b00};
   localparam logic [21:0] A_TIME = {`RTCZ_TIME_IDX, 2'b00};
   localparam logic [21:0] A_DATE = {`RTCZ_DATE_IDX, 2'b00};
   logic clk, rst_n, psel, penable, pwrite, pready, pslverr, irq;
   logic hz_pin, hz_oe, fine_pin, fine_oe, alt_en, p1, p2;
   logic [21:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0] pstrb;
   logic [7:0] h, m, s, hx;
   logic [32:0] exp_q [$];
   int miscompares, tests_run, e1, e2, at;
   // Selector table: code, loaded time and date, quiet cycles before the event (0: none)
   int sel_t [12] = '{0, 1, 2, 3, 3, 4, 4, 5, 5, 6, 6, 7};
   int qt_t [12] = '{0, 8, 24, 45, 0, 45, 0, 45, 0, 45, 0, 45};
   logic [31:0] tm_t [12] = '{32'h173B3A, 32'h0A141E, 32'h0A141E, 32'h0A143A, 32'h0A141E,
      32'h0A3B3A, 32'h0A143A, 32'h173B3A, 32'h0A3B3A, 32'h173B3A, 32'h173B3A, 32'h173B3A};
   logic [31:0] dt_t [12] = '{32'hC1F, 32'h305, 32'h305, 32'h305, 32'h305, 32'h305,
      32'h305, 32'h305, 32'h305, 32'h11F, 32'h305, 32'hC1F};

   // Short counts keep every event within a few hundred cycles
   rtcz_top #(.CLK_HZ(131072), .HALF_CNT(4)) dut (.CORE_CLK(clk), .RESETN(rst_n),
      .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
      .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .PERIODIC_TICK_IRQ(irq), .ONE_HZ_PIN(hz_pin), .ONE_HZ_PIN_OE(hz_oe),
      .FINE_CLOCK_PIN(fine_pin), .FINE_CLOCK_PIN_OE(fine_oe), .ALT_CLOCK_OUT_EN(alt_en));

   // ==========================================
   // Tasks
   task automatic chk(input logic [32:0] got, input logic [32:0] exp);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic stop_test;
      if (miscompares == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : stop_test

   // Request held until ready is seen at a rising edge
   task automatic apb(input logic wr, input logic [21:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [21:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr

   // Expected {error, data} noted before the read is issued
   task automatic rd(input logic [21:0] a, input logic [32:0] e);
      exp_q.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask : rd

   // Clock
   always #12.5 clk = ~clk;

   // Read monitor pairs each completed read with the oldest note
   always @(posedge clk) begin
      if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
         chk({pslverr, prdata}, exp_q.pop_front());
      end
   end

   // Watchdog, far beyond the few thousand cycles the sequence needs
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      stop_test;
   end

   // ==========================================
   // Main sequence
   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      pstrb = 4'hF;
      miscompares = 0;
      tests_run = 0;
      p1 = 1'b0;
      p2 = 1'b0;
      void'($urandom(68));
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      chk({30'h0, hz_oe, fine_oe, alt_en}, 33'h0);
      rd(A_CTL0, 33'h0);
      rd(A_CTL1, 33'h0);
      rd(A_STAT, 33'h0);
      rd(A_MASK, 33'h0);
      rd(A_TIME, 33'hC0000);
      rd(A_DATE, 33'h101);
      rd(22'h000010, 33'h100000000);
      wr(A_CTL0, 32'hFF);
      rd(A_CTL0, 33'hBF);
      // Pin activity over 400 cycles: 1 Hz is 32 cycles, fine clock 4 cycles
      e1 = 0;
      e2 = 0;
      repeat (400) begin
         @(posedge clk);
         if (hz_pin && !p1) e1++;
         if (fine_pin && !p2) e2++;
         p1 = hz_pin;
         p2 = fine_pin;
      end
      chk({31'h0, hz_oe, fine_oe}, 33'h3);
      chk(33'(e1 >= 11 && e1 <= 14), 33'h1);
      chk(33'(e2 >= 99 && e2 <= 101), 33'h1);
      wr(A_CTL0, 32'h30);
      wr(A_CTL0, 32'h0);
      repeat (3) @(posedge clk);
      chk({29'h0, hz_pin, fine_pin, hz_oe, fine_oe}, 33'h0);
      wr(A_CTL1, 32'h2);
      repeat (2) @(posedge clk);
      chk({32'h0, alt_en}, 33'h1);
      rd(A_CTL1, 33'h2);
      wr(A_CTL1, 32'h1);
      // Hour re-expressed on format change, boundaries then random hours
      for (int i = 0; i < 8; i++) begin
         h = (i == 0) ? 8'h00 : (i == 1) ? 8'h0C : 8'($urandom_range(23, 0));
         m = 8'($urandom_range(59, 0));
         s = 8'($urandom_range(59, 0));
         hx = ((h % 8'h0C) == 8'h00) ? 8'h0C : h % 8'h0C;
         hx = hx | ((h >= 8'h0C) ? 8'h20 : 8'h00);
         wr(A_CTL0, 32'h8);
         wr(A_TIME, {8'h0, h, m, s});
         rd(A_TIME, {9'h0, h, m, s});
         wr(A_CTL0, 32'h0);
         rd(A_TIME, {9'h0, hx, m, s});
      end
      wr(A_CTL1, 32'h0);
      // Counting only while run is set
      wr(A_CTL0, 32'h8);
      wr(A_TIME, 32'h0A141E);
      repeat (100) @(posedge clk);
      rd(A_TIME, 33'h0A141E);
      wr(A_CTL0, 32'h88);
      repeat (110) @(posedge clk);
      rd(A_TIME, 33'h0A1421);
      // Every selector code, firing and non-firing cases
      for (int i = 0; i < 12; i++) begin
         wr(A_CTL0, 32'h8 | 32'(sel_t[i]));
         wr(A_STAT, 32'h3);
         wr(A_MASK, 32'h3);
         wr(A_TIME, tm_t[i]);
         wr(A_DATE, dt_t[i]);
         wr(A_CTL0, 32'h88 | 32'(sel_t[i]));
         at = 0;
         for (int n = 1; n <= 130; n++) begin
            @(posedge clk);
            if (irq === 1'b1 && at == 0) at = n;
         end
         wr(A_CTL0, 32'h8);
         if (qt_t[i] == 0) begin
            chk(33'(at), 33'h0);
         end else begin
            chk(33'(at > qt_t[i] && at < 131), 33'h1);
            rd(A_STAT, 33'h3);
         end
         wr(A_STAT, 32'h3);
      end
      repeat (3) @(posedge clk);
      chk({32'h0, irq}, 33'h0);
      // Masked event stays pending, unmasking raises the line
      wr(A_MASK, 32'h0);
      wr(A_CTL0, 32'h89);
      repeat (40) @(posedge clk);
      chk({32'h0, irq}, 33'h0);
      rd(A_STAT, 33'h3);
      wr(A_MASK, 32'h1);
      repeat (3) @(posedge clk);
      chk({32'h0, irq}, 33'h1);
      wr(A_CTL0, 32'h0);
      wr(A_STAT, 32'h3);
      repeat (3) @(posedge clk);
      chk({32'h0, irq}, 33'h0);
      stop_test;
   end
endmodule : rtc_control_zero_bench
